/* pmrp_clkgen.sv */
`timescale 1ns/1ns
`include "pmrp_regs.svh"
module pmrp_clkgen #(
  parameter int DIV_10M = `PMRP_DIV_10M
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Synchronised reference and rate select
  input wire logic ref_lvl,
  input wire logic slow,
  // Edges and generated clock
  output logic ref_rise,
  output logic ref_fall,
  output logic clk_out,
  output logic clk_rise,
  output logic clk_fall
);
  localparam int HALF = DIV_10M / 2;

  generate
    if (DIV_10M < 2 || DIV_10M % 2 != 0 || HALF > 256) begin : g_bad
      $error("pmrp_clkgen: DIV_10M must be even, 2 to 512");
    end
  endgenerate

  logic ref_q;
  logic clk_q;
  logic [7:0] cnt;
  wire cnt_wrap = (cnt == 8'(HALF - 1));
  wire next_clk = slow ? ((ref_rise && cnt_wrap) ? ~clk_out : clk_out) : ref_lvl;

  assign ref_rise = ref_lvl & ~ref_q;
  assign ref_fall = ~ref_lvl & ref_q;
  assign clk_rise = clk_out & ~clk_q;
  assign clk_fall = ~clk_out & clk_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_q <= 1'b0;
      clk_q <= 1'b0;
      clk_out <= 1'b0;
      cnt <= 8'h00;
    end else begin
      ref_q <= ref_lvl;
      clk_q <= clk_out;
      clk_out <= next_clk;
      if (ref_rise) begin
        cnt <= cnt_wrap ? 8'h00 : cnt + 8'h01;
      end
    end
  end
endmodule // pmrp_clkgen

/* pmrp_mac_model.sv */
`timescale 1ns/1ns
module pmrp_mac_model (
  // Clocks and interface form
  input wire logic tx_clk,
  input wire logic ref_clk,
  input wire logic rmii,
  // MAC transmit pins
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er
);
  // Transmit pins start low and stay low until the first send drives them
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end
  // RMII has no transmit clock, so the reference edge paces the MAC
  task automatic edge_wait();
    if (rmii) begin
      @(posedge ref_clk);
    end else begin
      @(posedge tx_clk);
    end
  endtask
  task automatic send(input logic [3:0] v, input logic e, input int n);
    for (int i = 0; i < n; i++) begin
      edge_wait();
      tx_en <= 1'b1;
      txd <= rmii ? {2'b00, v[1:0]} : v;
      tx_er <= rmii ? 1'b0 : e;
    end
    edge_wait();
    tx_en <= 1'b0;
    txd <= 4'h0;
    tx_er <= 1'b0;
  endtask
endmodule // pmrp_mac_model

/* pmrp_pkg.sv */
package pmrp_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } pmrp_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_WAIT_SFD = 3'b010,
    RX_DATA = 3'b100
  } pmrp_rx_st_t;
endpackage

/* pmrp_port.sv */
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`include "pmrp_regs.svh"
module pmrp_port
  import pmrp_pkg::*;
#(
  parameter int DIV_10M = `PMRP_DIV_10M
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // Reference clock and external reset pins
  input wire logic ref_clk,
  input wire logic ext_reset_n,
  // MAC transmit pins and MII clocks
  input wire logic [3:0] txd,
  input wire logic tx_en,
  output logic tx_clk,
  output logic rx_clk,
  // Shared interrupt / transmit error pin
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  // Receive pins
  input wire logic [3:0] rxd_in,
  output logic [3:0] rxd_out,
  output logic [3:0] rxd_oe,
  output logic rx_dv,
  output logic rx_er,
  input wire logic col_in,
  output logic col_out,
  output logic col_oe,
  // Line side of the transceiver core
  output logic [4:0] tx_line_data,
  output logic tx_line_en,
  input wire logic rx_line_valid,
  input wire logic [4:0] rx_line_sym,
  input wire logic rx_line_err,
  input wire logic line_col
);
  function automatic logic [4:0] enc_4b5b(input logic [3:0] n);
    case (n)
      4'h0: enc_4b5b = 5'h1e;
      4'h1: enc_4b5b = 5'h09;
      4'h2: enc_4b5b = 5'h14;
      4'h3: enc_4b5b = 5'h15;
      4'h4: enc_4b5b = 5'h0a;
      4'h5: enc_4b5b = 5'h0b;
      4'h6: enc_4b5b = 5'h0e;
      4'h7: enc_4b5b = 5'h0f;
      4'h8: enc_4b5b = 5'h12;
      4'h9: enc_4b5b = 5'h13;
      4'ha: enc_4b5b = 5'h16;
      4'hb: enc_4b5b = 5'h17;
      4'hc: enc_4b5b = 5'h1a;
      4'hd: enc_4b5b = 5'h1b;
      4'he: enc_4b5b = 5'h1c;
      default: enc_4b5b = 5'h1d;
    endcase
  endfunction

  // Returns {invalid, nibble}
  function automatic logic [4:0] dec_5b4b(input logic [4:0] s);
    case (s)
      5'h1e: dec_5b4b = 5'h00;
      5'h09: dec_5b4b = 5'h01;
      5'h14: dec_5b4b = 5'h02;
      5'h15: dec_5b4b = 5'h03;
      5'h0a: dec_5b4b = 5'h04;
      5'h0b: dec_5b4b = 5'h05;
      5'h0e: dec_5b4b = 5'h06;
      5'h0f: dec_5b4b = 5'h07;
      5'h12: dec_5b4b = 5'h08;
      5'h13: dec_5b4b = 5'h09;
      5'h16: dec_5b4b = 5'h0a;
      5'h17: dec_5b4b = 5'h0b;
      5'h1a: dec_5b4b = 5'h0c;
      5'h1b: dec_5b4b = 5'h0d;
      5'h1c: dec_5b4b = 5'h0e;
      5'h1d: dec_5b4b = 5'h0f;
      default: dec_5b4b = 5'h10;
    endcase
  endfunction

  // Pin synchronisers
  logic [12:0] syn;
  wire rst_s = syn[12];
  wire ref_s = syn[11];
  wire col_s = syn[10];
  wire pin1_s = syn[9];
  wire tx_en_s = syn[8];
  wire [3:0] txd_s = syn[7:4];
  wire [3:0] rxd_s = syn[3:0];

  pmrp_sync #(.W(13)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .d({ext_reset_n, ref_clk, col_in, shared_pin_in, tx_en, txd, rxd_in}),
    .q(syn)
  );

  // Registers and strap state
  logic speed100;
  logic sym_mode;
  logic rmii;
  logic irq_sel;
  logic [2:0] mode;
  logic rst_q;
  logic [`PMRP_IRQ_W-1:0] irq_st;
  logic [`PMRP_IRQ_W-1:0] irq_mask;
  pmrp_tx_st_t tx_st;
  pmrp_rx_st_t rx_st;
  logic [7:0] sfd_sh;
  wire rst_rel = rst_s & ~rst_q;

  // Clock generation
  logic ref_fall;
  logic gen_clk;
  logic gen_fall;

  pmrp_clkgen #(.DIV_10M(DIV_10M)) u_clkgen (
    .mclk(mclk),
    .srst(srst),
    .ref_lvl(ref_s),
    .slow(~speed100),
    .ref_rise(),
    .ref_fall(ref_fall),
    .clk_out(gen_clk),
    .clk_rise(),
    .clk_fall(gen_fall)
  );
  assign tx_clk = ~rmii & gen_clk;
  assign rx_clk = ~rmii & gen_clk;
  // Sample mid-period, away from the edge the MAC launches on
  wire smp = rst_s & (rmii ? ref_fall : gen_fall);

  // Transmit path
  wire tx_er_in = ~irq_sel & pin1_s;
  wire [4:0] next_tx_data =
    rmii ? {3'b000, txd_s[1:0]} :
    !speed100 ? {1'b0, txd_s} :
    sym_mode ? {tx_er_in, txd_s} :
    tx_er_in ? `PMRP_CODE_H : enc_4b5b(txd_s);
  wire h_sub = speed100 & ~rmii & ~sym_mode & tx_er_in & tx_en_s;

  always_ff @(posedge mclk) begin
    if (srst || !rst_s) begin
      tx_st <= TX_IDLE;
      tx_line_data <= 5'h00;
      tx_line_en <= 1'b0;
    end else if (smp) begin
      tx_line_en <= tx_en_s;
      tx_line_data <= tx_en_s ? next_tx_data : 5'h00;
      case (tx_st)
        TX_IDLE: tx_st <= tx_en_s ? TX_SEND : TX_IDLE;
        TX_SEND: tx_st <= tx_en_s ? TX_SEND : TX_IDLE;
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Receive path
  wire [4:0] dec = dec_5b4b(rx_line_sym);
  wire rmii10 = rmii & ~speed100;
  wire rx_pass = (rx_st == RX_DATA) || (rx_st == RX_IDLE && !rmii10);
  wire [7:0] next_sfd_sh = {rx_line_sym[1:0], sfd_sh[7:2]};
  wire rx_err_now = rx_line_valid & (rx_line_err | (speed100 & ~rmii & dec[4]));
  wire [3:0] next_rxd =
    !rx_line_valid || !rx_pass ? 4'h0 :
    rmii ? {2'b00, rx_line_sym[1:0]} :
    (sym_mode || !speed100) ? rx_line_sym[3:0] : dec[3:0];
  wire next_rx_er = (!rmii && sym_mode) ? rx_line_sym[4] : rx_err_now;

  always_ff @(posedge mclk) begin
    if (srst || !rst_s) begin
      rx_st <= RX_IDLE;
      sfd_sh <= 8'h00;
      rxd_out <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      col_out <= 1'b0;
    end else if (smp) begin
      rxd_out <= next_rxd;
      rx_dv <= ~rmii & rx_line_valid;
      rx_er <= next_rx_er;
      col_out <= rmii ? rx_line_valid : line_col;
      sfd_sh <= next_sfd_sh;
      case (rx_st)
        RX_IDLE:
          if (rx_line_valid) begin
            rx_st <= rmii10 ? RX_WAIT_SFD : RX_DATA;
          end
        RX_WAIT_SFD:
          if (!rx_line_valid) begin
            rx_st <= RX_IDLE;
          end else if (next_sfd_sh == `PMRP_SFD) begin
            rx_st <= RX_DATA;
          end
        RX_DATA:
          if (!rx_line_valid) begin
            rx_st <= RX_IDLE;
          end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Straps and pin enables
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_q <= 1'b0;
      rmii <= 1'b0;
      irq_sel <= 1'b1;
      mode <= `PMRP_MODE_RST;
      rxd_oe <= 4'h0;
      col_oe <= 1'b0;
    end else begin
      rst_q <= rst_s;
      rxd_oe <= {4{rst_s}};
      col_oe <= rst_s;
      if (rst_rel) begin
        rmii <= col_s;
        irq_sel <= rxd_s[3];
        mode <= rxd_s[2:0];
      end
    end
  end

  // Open-drain interrupt on the shared pin
  wire irq_out_n = ~(irq_sel & irq & rst_s);
  assign shared_pin_out = 1'b0;
  assign shared_pin_oe = ~irq_out_n;

  // Register bus
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = (wb_adr_i == `PMRP_ADR_CTRL);
  wire hit_stat = (wb_adr_i == `PMRP_ADR_STAT);
  wire hit_ist = (wb_adr_i == `PMRP_ADR_IRQ_STAT);
  wire hit_imask = (wb_adr_i == `PMRP_ADR_IRQ_MASK);
  wire [6:0] stat_word = {rx_st != RX_IDLE, tx_st != TX_IDLE, mode, irq_sel, rmii};
  wire [`PMRP_IRQ_W-1:0] ev;
  wire [`PMRP_IRQ_W-1:0] ist_clr = (wb_wr && hit_ist) ? wb_dat_i[`PMRP_IRQ_W-1:0] : '0;
  wire [`PMRP_IRQ_W-1:0] next_irq_st = (irq_st & ~ist_clr) | ev;
  logic [31:0] next_rdata;

  assign ev[`PMRP_IRQ_TX_START] = smp & tx_en_s & (tx_st == TX_IDLE);
  assign ev[`PMRP_IRQ_TX_ERR] = smp & h_sub;
  assign ev[`PMRP_IRQ_RX_ERR] = smp & rx_err_now & ~(~rmii & sym_mode);
  assign ev[`PMRP_IRQ_RX_END] = smp & ~rx_line_valid & (rx_st != RX_IDLE);
  assign irq = |(irq_st & irq_mask);

  always_comb begin
    if (hit_ctrl) begin
      next_rdata = {30'h0, sym_mode, speed100};
    end else if (hit_stat) begin
      next_rdata = {25'h0, stat_word};
    end else if (hit_ist) begin
      next_rdata = {28'h0, irq_st};
    end else if (hit_imask) begin
      next_rdata = {28'h0, irq_mask};
    end else begin
      next_rdata = 32'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      speed100 <= 1'(`PMRP_CTRL_RST);
      sym_mode <= 1'b0;
      irq_st <= '0;
      irq_mask <= '0;
    end else begin
      wb_ack_o <= wb_req;
      irq_st <= next_irq_st;
      if (wb_req) begin
        wb_dat_o <= next_rdata;
      end
      if (wb_wr && hit_ctrl) begin
        speed100 <= wb_dat_i[`PMRP_CTRL_SPEED100];
        sym_mode <= wb_dat_i[`PMRP_CTRL_SYMBOL];
      end
      if (wb_wr && hit_imask) begin
        irq_mask <= wb_dat_i[`PMRP_IRQ_W-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_release;
    !rst_s ##1 rst_s;
  endsequence
  sequence s_tx_smp_mii;
    smp && !rmii && tx_en_s;
  endsequence
  a_tx_err_code: assert property (
    s_tx_smp_mii and (speed100 && !sym_mode && tx_er_in)
    |=> tx_line_data == `PMRP_CODE_H && tx_line_en)
    else $error("transmit error did not give /H/");
  a_tx_10m_plain: assert property (
    s_tx_smp_mii and !speed100 |=> tx_line_data == {1'b0, $past(txd_s)})
    else $error("10 Mb/s transmit data altered");
  a_tx_sym_msb: assert property (
    s_tx_smp_mii and (speed100 && sym_mode) |=> tx_line_data[4] == $past(tx_er_in))
    else $error("symbol bit 4 not taken from shared pin");
  a_rmii_tx_low: assert property (
    rmii |-> tx_line_data[4:2] == 3'h0)
    else $error("RMII upper transmit bits used");
  a_txclk_rmii_idle: assert property (
    rmii |-> !tx_clk && !rx_clk)
    else $error("transmit clock running in RMII");
  a_txclk_follow: assert property (
    !rmii && speed100 && !rst_rel ##1 !rmii |-> tx_clk == $past(ref_s))
    else $error("100 Mb/s transmit clock not following reference");
  a_rx_sym_msb: assert property (
    smp && !rmii && sym_mode |=> rx_er == $past(rx_line_sym[4]))
    else $error("receive error pin lacks symbol bit 4");
  a_rx_err_flag: assert property (
    smp && rx_line_valid && rx_line_err && !(!rmii && sym_mode) |=> rx_er)
    else $error("receive error not reported");
  a_rx_dv_mii: assert property (
    smp && !rmii |=> rx_dv == $past(rx_line_valid))
    else $error("receive valid does not follow data");
  a_rmii_unused: assert property (
    rmii |-> !rx_dv && rxd_out[3:2] == 2'b00)
    else $error("unused RMII receive pins active");
  a_sfd_hold: assert property (
    rx_st == RX_WAIT_SFD |-> rxd_out == 4'h0)
    else $error("receive data not held low before SFD");
  a_strap_irq: assert property (
    s_release |=> irq_sel == $past(rxd_s[3]))
    else $error("interrupt pin strap not latched");
  a_strap_mode: assert property (
    s_release |=> mode == $past(rxd_s[2:0]) && rxd_oe == 4'hf)
    else $error("mode strap not latched or pins not returned");
  a_strap_rmii: assert property (
    s_release |=> rmii == $past(col_s))
    else $error("RMII strap not latched");
endmodule // pmrp_port

/* pmrp_port_tb.sv */
`timescale 1ns/1ns
`include "pmrp_regs.svh"
module pmrp_port_tb;
  logic mclk = 1'b0, srst = 1'b1, ref_clk = 1'b0, ext_n = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_dat_o;
  logic wb_ack_o, irq, tx_clk, rx_clk, shared_pin_in, shared_pin_out, shared_pin_oe;
  logic [3:0] rxd_in, rxd_out, rxd_oe, txd, strap_rxd = 4'hf;
  logic rx_dv, rx_er, col_in, col_out, col_oe, tx_en, mac_er, strap_col = 1'b0;
  logic [4:0] tx_line_data, rx_line_sym = 5'h00;
  logic tx_line_en, rx_line_valid = 1'b0, rx_line_err = 1'b0, line_col = 1'b0;
  int n_mismatch = 0, checks = 0, cyc_n = 0, clk_hi = 0;

  always #25 mclk = ~mclk;
  initial begin
    #13;
    forever #200 ref_clk = ~ref_clk;
  end
  always @(posedge mclk) begin
    cyc_n <= cyc_n + 1;
    if (tx_clk === 1'b1 || rx_clk === 1'b1) begin
      clk_hi <= clk_hi + 1;
    end
    if (cyc_n == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // Pull-ups on receive data and shared pin, pull-down on collision
  assign rxd_in = (rxd_oe & rxd_out) | (~rxd_oe & strap_rxd);
  assign col_in = col_oe ? col_out : strap_col;
  assign shared_pin_in = shared_pin_oe ? shared_pin_out : (strap_rxd[3] ? 1'b1 : mac_er);

  pmrp_port #(.DIV_10M(2)) pmrp_port_inst (
    .mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_sel_i(wb_sel), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .ref_clk(ref_clk), .ext_reset_n(ext_n), .txd(txd),
    .tx_en(tx_en), .tx_clk(tx_clk), .rx_clk(rx_clk), .shared_pin_in(shared_pin_in),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rx_dv(rx_dv), .rx_er(rx_er), .col_in(col_in),
    .col_out(col_out), .col_oe(col_oe), .tx_line_data(tx_line_data),
    .tx_line_en(tx_line_en), .rx_line_valid(rx_line_valid), .rx_line_sym(rx_line_sym),
    .rx_line_err(rx_line_err), .line_col(line_col));
  pmrp_mac_model pmrp_mac_model_inst (
    .tx_clk(tx_clk), .ref_clk(ref_clk), .rmii(strap_col), .txd(txd), .tx_en(tx_en),
    .tx_er(mac_er));

  task automatic stop_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t register got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t pins got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hf;
    wb_adr <= a;
    wb_dat <= d;
    // Hold the request until ack is seen high at a rising edge
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge mclk);
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk_reg(q, exp);
  endtask
  task automatic tx(input logic [3:0] v, input logic e, input logic [4:0] exp);
    pmrp_mac_model_inst.send(v, e, 4);
    @(negedge mclk);
    chk_pin({4'h0, tx_line_en}, 5'h01);
    chk_pin(tx_line_data, exp);
    repeat (40) @(negedge mclk);
    chk_pin({4'h0, tx_line_en}, 5'h00);
  endtask
  task automatic strap(input logic c, input logic [3:0] r, input logic [31:0] exp);
    @(posedge mclk);
    ext_n <= 1'b0;
    strap_col <= c;
    strap_rxd <= r;
    repeat (9) @(posedge mclk);
    @(negedge mclk);
    chk_pin({rxd_oe, col_oe}, 5'h00);
    @(posedge mclk);
    ext_n <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(`PMRP_ADR_STAT, exp);
    @(negedge mclk);
    chk_pin({rxd_oe, col_oe}, 5'h1f);
  endtask
  task automatic rdib(input logic [1:0] d);
    @(posedge ref_clk);
    @(posedge mclk);
    rx_line_valid <= 1'b1;
    rx_line_sym <= {3'h0, d};
  endtask
  task automatic rline(input logic v, input logic [4:0] s, input logic e);
    @(posedge mclk);
    rx_line_valid <= v;
    rx_line_sym <= s;
    rx_line_err <= e;
    repeat (40) @(negedge mclk);
  endtask

  task automatic t_regs();
    rd(`PMRP_ADR_CTRL, 32'h1);
    rd(`PMRP_ADR_STAT, 32'h1e);
    wr(8'h10, 32'hff);
    rd(8'h10, 32'h0);
  endtask
  task automatic t_irq();
    wr(`PMRP_ADR_IRQ_MASK, 32'hf);
    wr(`PMRP_ADR_CTRL, 32'h0);
    tx(4'h9, 1'b0, 5'h09);
    chk_pin({3'h0, irq, shared_pin_oe}, 5'h03);
    rd(`PMRP_ADR_IRQ_STAT, 32'h1);
    wr(`PMRP_ADR_IRQ_STAT, 32'h1);
    rd(`PMRP_ADR_IRQ_STAT, 32'h0);
    chk_pin({3'h0, irq, shared_pin_oe}, 5'h00);
    wr(`PMRP_ADR_IRQ_MASK, 32'h0);
    tx(4'h6, 1'b0, 5'h06);
    chk_pin({3'h0, irq, shared_pin_oe}, 5'h00);
    rd(`PMRP_ADR_IRQ_STAT, 32'h1);
    wr(`PMRP_ADR_IRQ_STAT, 32'hf);
  endtask
  task automatic t_txer();
    strap(1'b0, 4'h5, 32'h14);
    wr(`PMRP_ADR_IRQ_MASK, 32'hf);
    wr(`PMRP_ADR_CTRL, 32'h1);
    tx(4'h3, 1'b1, `PMRP_CODE_H);
    chk_pin({3'h0, irq, shared_pin_oe}, 5'h02);
    rd(`PMRP_ADR_IRQ_STAT, 32'h3);
    wr(`PMRP_ADR_IRQ_STAT, 32'hf);
    wr(`PMRP_ADR_CTRL, 32'h0);
    tx(4'h3, 1'b1, 5'h03);
    wr(`PMRP_ADR_CTRL, 32'h3);
    tx(4'h5, 1'b1, 5'h15);
  endtask
  task automatic t_rmii();
    int c0;
    strap(1'b1, 4'hf, 32'h1f);
    wr(`PMRP_ADR_CTRL, 32'h1);
    c0 = clk_hi;
    tx(4'he, 1'b0, 5'h02);
    chk_pin({4'h0, clk_hi != c0}, 5'h00);
    wr(`PMRP_ADR_CTRL, 32'h0);
    repeat (4) rdib(2'b01);
    repeat (4) @(negedge mclk);
    chk_pin({rxd_out, rx_dv}, 5'h00);
    chk_pin({4'h0, col_out}, 5'h01);
    rdib(2'b11);
    rdib(2'b10);
    rdib(2'b10);
    repeat (4) @(negedge mclk);
    chk_pin({rxd_out, rx_dv}, 5'h04);
    rline(1'b0, 5'h00, 1'b0);
  endtask
  task automatic t_rx();
    strap(1'b0, 4'hf, 32'h1e);
    wr(`PMRP_ADR_CTRL, 32'h0);
    rline(1'b1, 5'h0a, 1'b1);
    chk_pin({rxd_out, rx_dv}, 5'h15);
    chk_pin({4'h0, rx_er}, 5'h01);
    wr(`PMRP_ADR_CTRL, 32'h2);
    rline(1'b1, 5'h1c, 1'b0);
    chk_pin({rx_er, rxd_out}, 5'h1c);
    wr(`PMRP_ADR_CTRL, 32'h1);
    rline(1'b1, 5'h0b, 1'b0);
    chk_pin({rxd_out, rx_dv}, 5'h0b);
    rline(1'b1, 5'h00, 1'b0);
    chk_pin({4'h0, rx_er}, 5'h01);
    @(posedge mclk);
    line_col <= 1'b1;
    repeat (40) @(negedge mclk);
    chk_pin({4'h0, col_out}, 5'h01);
    @(posedge mclk);
    line_col <= 1'b0;
    rline(1'b0, 5'h00, 1'b0);
    chk_pin({4'h0, rx_dv}, 5'h00);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_irq();
    t_txer();
    t_rmii();
    t_rx();
    stop_test();
  end
endmodule // pmrp_port_tb

/* pmrp_regs.svh */
`ifndef PMRP_REGS_SVH
`define PMRP_REGS_SVH
`define PMRP_ADR_CTRL 8'h00
`define PMRP_ADR_STAT 8'h04
`define PMRP_ADR_IRQ_STAT 8'h08
`define PMRP_ADR_IRQ_MASK 8'h0c
`define PMRP_CTRL_SPEED100 0
`define PMRP_CTRL_SYMBOL 1
`define PMRP_CTRL_RST 2'h1
`define PMRP_STAT_RMII 0
`define PMRP_STAT_IRQ_SEL 1
`define PMRP_STAT_MODE_LO 2
`define PMRP_STAT_TX_BUSY 5
`define PMRP_STAT_RX_BUSY 6
`define PMRP_IRQ_W 4
`define PMRP_IRQ_TX_START 0
`define PMRP_IRQ_TX_ERR 1
`define PMRP_IRQ_RX_ERR 2
`define PMRP_IRQ_RX_END 3
`define PMRP_MODE_RST 3'h7
`define PMRP_TXCLK_100_KHZ 25000
`define PMRP_TXCLK_10_KHZ 2500
`define PMRP_DIV_10M (`PMRP_TXCLK_100_KHZ / `PMRP_TXCLK_10_KHZ)
`define PMRP_CODE_H 5'h04
`define PMRP_SFD 8'hd5
`endif

/* pmrp_sync.sv */
`timescale 1ns/1ns
module pmrp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk) begin
    if (srst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pmrp_sync
